/* File: design/omcs_pkg.sv */
`default_nettype none
package omcs_pkg;
	// System clock rate in MHz
	localparam int CLK_MHZ = 20;
	// Longest times, in their own units, and their cycle counts
	localparam int T_FAULT_US = 100;
	localparam int T_FAULT_CYC = T_FAULT_US * CLK_MHZ;
	localparam int T_OFF_US = 10;
	localparam int T_OFF_CYC = T_OFF_US * CLK_MHZ;
	localparam int T_ON_MS = 1;
	localparam int T_ON_CYC = T_ON_MS * 1000 * CLK_MHZ;
	localparam int T_LOS_US = 100;
	localparam int T_LOS_CYC = T_LOS_US * CLK_MHZ;
	localparam int T_INIT_MS = 300;
	localparam int T_INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
	// Least hold time of the disable input that resets a latched fault
	localparam int T_RESET_US = 10;
	localparam int T_RESET_CYC = T_RESET_US * CLK_MHZ;
	// Fastest serial clock the host may use
	localparam int F_SCL_MAX_KHZ = 400;
	// Counter widths
	localparam int INIT_CNT_W = 23;
	localparam int DIS_CNT_W = 8;
	// Serial device addresses of the two pages
	localparam logic [6:0] DEV_ID_ADDR = 7'h50;
	localparam logic [6:0] DEV_DIAG_ADDR = 7'h51;
	// Identification page: one coded byte, the rest reads zero
	localparam logic [7:0] ID_IDENT_ADDR = 8'h00;
	localparam logic [7:0] ID_IDENT_CODE = 8'h5a; // Arbitrary value
	// Diagnostic page layout: five 16-bit values, high byte first
	localparam int N_CH = 5;
	localparam logic [7:0] DG_TEMP = 8'h60;
	localparam logic [7:0] DG_VCC = 8'h62;
	localparam logic [7:0] DG_BIAS = 8'h64;
	localparam logic [7:0] DG_TXP = 8'h66;
	localparam logic [7:0] DG_RXP = 8'h68;
	localparam logic [7:0] DG_STATUS = 8'h6e;
	// Status byte bit positions
	localparam int SB_DIS = 7;
	localparam int SB_CAL = 5;
	localparam int SB_FAULT = 2;
	localparam int SB_LOS = 1;
	localparam int SB_INIT = 0;
	// Internal calibration: value = raw * slope / 256 + offset
	localparam logic [15:0] CAL_SLOPE = 16'h0100;
	localparam logic [15:0] CAL_OFFSET = 16'h0000;
	// Reset values of the status flags and of the serial clock and data copies
	localparam logic FAULT_RST = 1'b1;
	localparam logic LOS_RST = 1'b1;
	localparam logic BUS_IDLE_RST = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_RX_ACK = 3'h2,
		ST_TX = 3'h3,
		ST_TX_ACK = 3'h4
	} omcs_i2c_st_t;

	// All system-domain state
	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_d;
		logic sda_m;
		logic sda_s;
		logic sda_d;
		logic dis_m;
		logic dis_s;
		logic flt_m;
		logic flt_s;
		logic sd_m;
		logic sd_s;
		logic [INIT_CNT_W-1:0] init_cnt;
		logic init_done;
		logic [DIS_CNT_W-1:0] dis_cnt;
		logic tx_fault;
		logic tf_oe;
		logic rx_signal_absent_flag;
		logic los_oe;
		logic laser_en;
		logic pres_o;
		logic pres_oe;
		logic pu_en;
		logic sda_o;
		logic sda_oe;
		omcs_i2c_st_t st;
		logic [2:0] bitcnt;
		logic byte_done;
		logic first;
		logic got_addr;
		logic rw;
		logic page;
		logic nack;
		logic [7:0] shreg;
		logic [7:0] txsh;
		logic [7:0] addr;
		logic [N_CH-1:0][15:0] snap;
	} omcs_sys_t;

	// Serial-clock domain state: the data bit caught on each clock rise
	typedef struct packed {
		logic bit_smp;
	} omcs_link_t;
endpackage
`default_nettype wire

/* File: design/omcs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module omcs_top
	import omcs_pkg::*;
#(
	parameter int INIT_CYC = T_INIT_CYC
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic scl_clk_in,
	input wire logic sda_in,
	input wire logic tx_disable_in,
	input wire logic laser_fault_in,
	input wire logic rx_signal_detect_in,
	input wire logic cal_internal_in,
	input wire logic [15:0] temp_raw_in,
	input wire logic [15:0] vcc_raw_in,
	input wire logic [15:0] bias_raw_in,
	input wire logic [15:0] txpwr_raw_in,
	input wire logic [15:0] rxpwr_raw_in,
	output logic tx_fault_out,
	output logic tx_fault_oe_out,
	output logic rx_signal_absent_flag_out,
	output logic rx_signal_absent_flag_oe_out,
	output logic laser_en_out,
	output logic mod_present_out,
	output logic mod_present_oe_out,
	output logic tx_disable_pullup_en_out,
	output logic sda_out,
	output logic sda_oe_out
);

	// Whole system-domain state lives in one struct register; st_nxt is its
	// next value, filled in by the single combinational process below.
	omcs_sys_t st_r;
	omcs_sys_t st_nxt;
	omcs_link_t lk_r;
	omcs_link_t lk_nxt;
	logic [N_CH-1:0][15:0] adc_raw;
	logic [N_CH-1:0][15:0] rep_val;

	// Internal calibration of one monitor reading. The product is kept at full
	// width so a slope above one cannot overflow before the scaling shift;
	// a result above 16 bits is cut, and the host sees the low word.
	function automatic logic [15:0] cal_apply(input logic [15:0] raw);
		logic [31:0] prod;
		prod = raw * CAL_SLOPE;
		return prod[23:8] + CAL_OFFSET;
	endfunction

	// Byte seen by the host at an address of either page.
	// Unmapped addresses read zero, so a host scanning the map sees no junk;
	// the diagnostic words come from the snapshot, not from the live inputs.
	function automatic logic [7:0] rd_byte(
		input logic pg,
		input logic [7:0] a,
		input logic [N_CH-1:0][15:0] sn,
		input logic [7:0] stat
	);
		logic [7:0] off;
		off = a - DG_TEMP;
		if (!pg) begin
			return (a == ID_IDENT_ADDR) ? ID_IDENT_CODE : 8'h00;
		end
		if (a >= DG_TEMP && off < 8'(2 * N_CH)) begin
			return off[0] ? sn[off[3:1]][7:0] : sn[off[3:1]][15:8];
		end
		if (a == DG_STATUS) begin
			return stat;
		end
		return 8'h00;
	endfunction

	// Monitor channels in address order
	assign adc_raw = {rxpwr_raw_in, txpwr_raw_in, bias_raw_in, vcc_raw_in, temp_raw_in};

	// Calibration style chosen per read; raw values suit host-side calibration
	// The style input is read live, so a change takes effect at the next start.
	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_cal
			assign rep_val[g] = cal_internal_in ? cal_apply(adc_raw[g]) : adc_raw[g];
		end
	endgenerate

	// Serial-clock domain: catch the data bit right at the host's clock rise.
	// It then stands for a whole clock period, so the system domain may read it
	// once its own synchronised copy of the clock shows the rise.
	always_comb begin
		lk_nxt = lk_r;
		lk_nxt.bit_smp = sda_in;
	end

	// Data only, no control; it is defined by the first clock rise of a frame
	// Left without reset: its value matters only after a clock rise.
	always_ff @(posedge scl_clk_in) begin
		lk_r <= lk_nxt;
	end

	// System domain: pin synchronisers, transmitter control and serial slave
	always_comb begin
		logic [7:0] stat;
		logic [7:0] rb;
		logic [7:0] nb;
		logic start_ev;
		logic stop_ev;
		logic rise_ev;
		logic fall_ev;
		logic dev_hit;
		stat = 8'h00;
		rb = 8'h00;
		nb = 8'h00;
		start_ev = 1'b0;
		stop_ev = 1'b0;
		rise_ev = 1'b0;
		fall_ev = 1'b0;
		dev_hit = 1'b0;
		st_nxt = st_r;

		// Two flops on the serial, disable, fault and detect pins; the slave takes data bits from the serial-clock-domain catch instead
		// The serial clock and data each get a third flop so edges are seen as old/new pairs;
		// at 400 kHz a clock phase spans dozens of system cycles, so no edge is lost.
		st_nxt.scl_m = scl_clk_in;
		st_nxt.scl_s = st_r.scl_m;
		st_nxt.scl_d = st_r.scl_s;
		st_nxt.sda_m = sda_in;
		st_nxt.sda_s = st_r.sda_m;
		st_nxt.sda_d = st_r.sda_s;
		st_nxt.dis_m = tx_disable_in;
		st_nxt.dis_s = st_r.dis_m;
		st_nxt.flt_m = laser_fault_in;
		st_nxt.flt_s = st_r.flt_m;
		st_nxt.sd_m = rx_signal_detect_in;
		st_nxt.sd_s = st_r.sd_m;

		// Fixed pin drives: presence pulled low, disable pull-up on
		st_nxt.pres_o = 1'b0;
		st_nxt.pres_oe = 1'b1;
		st_nxt.pu_en = 1'b1;
		st_nxt.sda_o = 1'b0;

		// Disable hold timer, saturating at the fault-reset hold time
		// Saturation keeps the clear condition true while the host holds the
		// input, so a fault that goes away late is still cleared.
		if (st_r.dis_s) begin
			if (st_r.dis_cnt != DIS_CNT_W'(T_RESET_CYC)) begin
				st_nxt.dis_cnt = st_r.dis_cnt + 1'b1;
			end
		end else begin
			st_nxt.dis_cnt = '0;
		end

		// Fault flag: held during start-up, then a latch where the set wins
		// A fault present at the end of start-up stays flagged; a fault and a
		// clear in one cycle leave the flag set.
		if (!st_r.init_done) begin
			if (st_r.init_cnt == INIT_CNT_W'(INIT_CYC - 1)) begin
				st_nxt.init_done = 1'b1;
				st_nxt.tx_fault = st_r.flt_s;
			end else begin
				st_nxt.init_cnt = st_r.init_cnt + 1'b1;
			end
		end else if (st_r.flt_s) begin
			st_nxt.tx_fault = 1'b1;
		end else if (st_r.dis_cnt == DIS_CNT_W'(T_RESET_CYC)) begin
			st_nxt.tx_fault = 1'b0;
		end
		// Open collector: pull low while there is no fault
		st_nxt.tf_oe = ~st_nxt.tx_fault;

		// Laser also dark while faulted, for eye safety
		// Uses the next fault value so the laser goes dark in the same cycle
		// as the flag rises, never a cycle later.
		st_nxt.laser_en = st_nxt.init_done & ~st_r.dis_s & ~st_nxt.tx_fault;

		// Signal-loss flag tracks the receiver detect, a few cycles late
		// No filtering: the receiver's own hysteresis keeps the detect clean.
		st_nxt.rx_signal_absent_flag = ~st_r.sd_s;
		st_nxt.los_oe = st_r.sd_s;

		// Bus conditions from the synchronised lines, same latency on both
		// A data change while the clock is high is a start (falling) or a stop
		// (rising); otherwise the host changes data only while the clock is low.
		start_ev = st_r.scl_s & st_r.scl_d & st_r.sda_d & ~st_r.sda_s;
		stop_ev = st_r.scl_s & st_r.scl_d & ~st_r.sda_d & st_r.sda_s;
		rise_ev = st_r.scl_s & ~st_r.scl_d;
		fall_ev = ~st_r.scl_s & st_r.scl_d;

		stat[SB_DIS] = st_r.dis_s;
		stat[SB_CAL] = cal_internal_in;
		stat[SB_FAULT] = st_r.tx_fault;
		stat[SB_LOS] = st_r.rx_signal_absent_flag;
		stat[SB_INIT] = st_r.init_done;
		rb = rd_byte(st_r.page, st_r.addr, st_r.snap, stat);
		nb = {st_r.shreg[6:0], lk_r.bit_smp};
		dev_hit = (st_r.shreg[7:1] == DEV_ID_ADDR) || (st_r.shreg[7:1] == DEV_DIAG_ADDR);

		// Serial slave; start and stop override any bit in progress
		// Each start also snapshots all monitor words, so the high and low byte
		// of one value always belong to the same reading.
		if (start_ev) begin
			st_nxt.st = ST_RX;
			st_nxt.bitcnt = 3'h0;
			st_nxt.byte_done = 1'b0;
			st_nxt.first = 1'b1;
			st_nxt.got_addr = 1'b0;
			st_nxt.sda_oe = 1'b0;
			st_nxt.snap = rep_val;
		end else if (stop_ev) begin
			st_nxt.st = ST_IDLE;
			st_nxt.sda_oe = 1'b0;
		end else begin
			case (st_r.st)
				ST_RX: begin
					if (rise_ev && !st_r.byte_done) begin
						st_nxt.shreg = nb;
						st_nxt.bitcnt = st_r.bitcnt + 1'b1;
						st_nxt.byte_done = (st_r.bitcnt == 3'h7);
					end else if (fall_ev && st_r.byte_done) begin
						if (st_r.first) begin
							// Answer only our own two addresses
							st_nxt.first = 1'b0;
							st_nxt.page = (st_r.shreg[7:1] == DEV_DIAG_ADDR);
							st_nxt.rw = st_r.shreg[0];
							st_nxt.sda_oe = dev_hit;
							st_nxt.st = dev_hit ? ST_RX_ACK : ST_IDLE;
						end else begin
							// First written byte is the address; later ones are dropped
							if (!st_r.got_addr) begin
								st_nxt.addr = st_r.shreg;
							end
							st_nxt.got_addr = 1'b1;
							st_nxt.sda_oe = 1'b1;
							st_nxt.st = ST_RX_ACK;
						end
					end
				end
				ST_RX_ACK: begin
					if (fall_ev) begin
						st_nxt.byte_done = 1'b0;
						st_nxt.bitcnt = 3'h0;
						if (st_r.rw) begin
							st_nxt.txsh = rb;
							st_nxt.sda_oe = ~rb[7];
							st_nxt.addr = st_r.addr + 1'b1;
							st_nxt.st = ST_TX;
						end else begin
							st_nxt.sda_oe = 1'b0;
							st_nxt.st = ST_RX;
						end
					end
				end
				ST_TX: begin
					// Data changes only after a clock fall, ready for the next rise
					if (fall_ev) begin
						if (st_r.bitcnt == 3'h7) begin
							st_nxt.sda_oe = 1'b0;
							st_nxt.bitcnt = 3'h0;
							st_nxt.st = ST_TX_ACK;
						end else begin
							st_nxt.sda_oe = ~st_r.txsh[6];
							st_nxt.txsh = {st_r.txsh[6:0], 1'b0};
							st_nxt.bitcnt = st_r.bitcnt + 1'b1;
						end
					end
				end
				// Host answers the byte on the ninth clock: a released line ends the read
				ST_TX_ACK: begin
					if (rise_ev) begin
						st_nxt.nack = lk_r.bit_smp;
					end else if (fall_ev) begin
						if (st_r.nack) begin
							st_nxt.st = ST_IDLE;
						end else begin
							st_nxt.txsh = rb;
							st_nxt.sda_oe = ~rb[7];
							st_nxt.addr = st_r.addr + 1'b1;
							st_nxt.st = ST_TX;
						end
					end
				end
				ST_IDLE: begin
					st_nxt.sda_oe = 1'b0;
				end
				default: begin
					st_nxt.st = ST_IDLE;
					st_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// One register for the whole system-domain state
	// Serial clock and data copies reset to the idle-high bus level so no false start follows reset.
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			st_r <= '0;
			st_r.scl_m <= BUS_IDLE_RST;
			st_r.scl_s <= BUS_IDLE_RST;
			st_r.scl_d <= BUS_IDLE_RST;
			st_r.sda_m <= BUS_IDLE_RST;
			st_r.sda_s <= BUS_IDLE_RST;
			st_r.sda_d <= BUS_IDLE_RST;
			st_r.tx_fault <= FAULT_RST;
			st_r.rx_signal_absent_flag <= LOS_RST;
			st_r.pres_oe <= 1'b1;
			st_r.pu_en <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// All outputs straight from flops
	// The pin enables are registered too, so no glitch reaches the open-drain pins.
	assign tx_fault_out = st_r.tx_fault;
	assign tx_fault_oe_out = st_r.tf_oe;
	assign rx_signal_absent_flag_out = st_r.rx_signal_absent_flag;
	assign rx_signal_absent_flag_oe_out = st_r.los_oe;
	assign laser_en_out = st_r.laser_en;
	assign mod_present_out = st_r.pres_o;
	assign mod_present_oe_out = st_r.pres_oe;
	assign tx_disable_pullup_en_out = st_r.pu_en;
	assign sda_out = st_r.sda_o;
	assign sda_oe_out = st_r.sda_oe;

endmodule // omcs_top
`default_nettype wire

/* File: tb/omcs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module omcs_checker
	import omcs_pkg::*;
#(
	parameter int INIT_CYC = 50
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic tx_disable_in,
	input wire logic laser_fault_in,
	input wire logic rx_signal_detect_in,
	input wire logic tx_fault_out,
	input wire logic tx_fault_oe_out,
	input wire logic rx_signal_absent_flag_out,
	input wire logic rx_signal_absent_flag_oe_out,
	input wire logic laser_en_out,
	input wire logic mod_present_out,
	input wire logic mod_present_oe_out,
	input wire logic tx_disable_pullup_en_out
);
	int dis_run;
	int since_rst;
	// Saturating counters, so long runs never wrap
	always_ff @(posedge sys_clk_in) begin
		dis_run <= tx_disable_in ? (dis_run < 999 ? dis_run + 1 : dis_run) : 0;
		since_rst <= resetn_in ? (since_rst < INIT_CYC + 9 ? since_rst + 1 : since_rst) : 0;
	end
	default clocking dc @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// Inputs pass two sync flops and one register: four samples cover it
	sequence s_dis_held;
		tx_disable_in [*4];
	endsequence
	sequence s_sig_gone;
		!rx_signal_detect_in [*4];
	endsequence
	sequence s_sig_back;
		rx_signal_detect_in [*4];
	endsequence
	fault_set_a: assert property ($rose(laser_fault_in) |-> ##3 tx_fault_out)
		else $error("fault flag late");
	dis_off_a: assert property (s_dis_held |-> !laser_en_out)
		else $error("laser on while disabled");
	laser_on_a: assert property (laser_en_out |-> !tx_fault_out && !$past(tx_disable_in, 3))
		else $error("laser on without cause");
	los_set_a: assert property (s_sig_gone |-> rx_signal_absent_flag_out && !rx_signal_absent_flag_oe_out)
		else $error("loss flag not raised");
	los_clr_a: assert property (since_rst > 3 ##0 s_sig_back |-> !rx_signal_absent_flag_out && rx_signal_absent_flag_oe_out)
		else $error("loss flag not cleared");
	presence_a: assert property (mod_present_oe_out && !mod_present_out && tx_disable_pullup_en_out)
		else $error("presence or pull-up lost");
	fault_oe_a: assert property (tx_fault_oe_out != tx_fault_out)
		else $error("fault pin drive wrong");
	fault_clr_a: assert property ($fell(tx_fault_out) |-> dis_run >= T_RESET_CYC || since_rst <= INIT_CYC + 4)
		else $error("fault cleared too early");
	init_hold_a: assert property (since_rst < INIT_CYC - 1 |-> tx_fault_out && !laser_en_out)
		else $error("init state left early");
endmodule // omcs_checker
bind omcs_top omcs_checker #(.INIT_CYC(INIT_CYC)) u_chk (.*);
`default_nettype wire

/* File: tb/omcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module omcs_host_model (
	output logic scl_out,
	output logic sda_line_out,
	output logic tx_disable_out,
	input wire logic sda_oe_in,
	input wire logic pullup_en_in
);
	localparam int Q = 625; // Quarter of a 400 kHz period
	logic sda_lo = 1'b0;
	logic scl_r = 1'b1;
	logic dis_drv = 1'b0;
	logic dis_val = 1'b0;
	// Host pull-ups: a wire is low only while someone pulls it
	assign sda_line_out = !(sda_lo || sda_oe_in);
	assign scl_out = scl_r;
	assign tx_disable_out = dis_drv ? dis_val : pullup_en_in;
	task set_dis(input logic drv, input logic val);
		dis_drv = drv;
		dis_val = val;
	endtask
	// Data moves only while the clock is low
	task bit_io(input logic b, output logic r);
		#Q sda_lo = !b;
		#Q scl_r = 1'b1;
		#Q r = sda_line_out;
		#Q scl_r = 1'b0;
	endtask
	task start;
		#Q sda_lo = 1'b0;
		#Q scl_r = 1'b1;
		#Q sda_lo = 1'b1;
		#Q scl_r = 1'b0;
	endtask
	// Eight bits then the ninth, which the host leaves released
	task xfer(input logic [7:0] w, output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], b);
			r[i] = b;
		end
		bit_io(1'b1, b);
		ack = !b;
	endtask
	task rd(input logic [6:0] dev, input logic [7:0] wa, output logic [7:0] d, output logic ok);
		logic [7:0] x;
		logic a1, a2, a3;
		start();
		xfer({dev, 1'b0}, x, a1);
		xfer(wa, x, a2);
		start();
		xfer({dev, 1'b1}, x, a3);
		xfer(8'hff, d, x[0]);
		#Q sda_lo = 1'b1;
		#Q scl_r = 1'b1;
		#Q sda_lo = 1'b0;
		#Q ok = a1 && a2 && a3;
	endtask
endmodule // omcs_host_model
`default_nettype wire

/* File: tb/optical_module_ctrl_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module optical_module_ctrl_status_tb_top;
	import omcs_pkg::*;
	localparam int INIT = 50;
	logic sys_clk_in, resetn_in, laser_fault_in, rx_signal_detect_in, cal_internal_in;
	logic [15:0] temp_raw_in, vcc_raw_in, bias_raw_in, txpwr_raw_in, rxpwr_raw_in;
	logic tx_fault_out, tx_fault_oe_out, rx_signal_absent_flag_out, rx_signal_absent_flag_oe_out;
	logic laser_en_out, mod_present_out, mod_present_oe_out, tx_disable_pullup_en_out, sda_out, sda_oe_out;
	wire logic scl_clk_in, sda_in, tx_disable_in;
	int n_errors = 0;
	int comparisons = 0;
	logic [15:0] raw [N_CH] = '{16'h1234, 16'h5678, 16'h9abc, 16'h0def, 16'h4321};
	logic [15:0] exp_v;
	logic [7:0] d;
	logic ok;
	omcs_top #(.INIT_CYC(INIT)) dut (.*);
	omcs_host_model host (.scl_out(scl_clk_in), .sda_line_out(sda_in), .tx_disable_out(tx_disable_in),
		.sda_oe_in(sda_oe_out), .pullup_en_in(tx_disable_pullup_en_out));
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// Monitor readings follow the table at each edge
	always @(posedge sys_clk_in) begin
		{temp_raw_in, vcc_raw_in, bias_raw_in, txpwr_raw_in, rxpwr_raw_in} <= {raw[0], raw[1], raw[2], raw[3], raw[4]};
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task summarize;
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard, well past the longest sequence
	initial begin
		#5000000;
		n_errors++;
		summarize();
	end
	initial begin
		resetn_in = 1'b0;
		laser_fault_in = 1'b0;
		rx_signal_detect_in = 1'b1;
		cal_internal_in = 1'b1;
		{temp_raw_in, vcc_raw_in, bias_raw_in, txpwr_raw_in, rxpwr_raw_in} = '0;
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		cyc(3);
		`CHK("fault_init", 2'b10, {tx_fault_out, laser_en_out})
		`CHK("present", 4'b1010, {mod_present_oe_out, mod_present_out, tx_disable_pullup_en_out, sda_out})
		host.set_dis(1'b1, 1'b0);
		cyc(INIT + 10);
		`CHK("init_done", 2'b01, {tx_fault_out, laser_en_out})
		host.rd(DEV_ID_ADDR, ID_IDENT_ADDR, d, ok);
		`CHK("id_byte", {1'b1, ID_IDENT_CODE}, {ok, d})
		host.rd(7'h2a, 8'h00, d, ok);
		`CHK("bad_dev", 1'b0, ok)
		// Both calibration styles over all five monitors
		for (int c = 0; c < 2; c++) begin
			@(posedge sys_clk_in) cal_internal_in <= c[0];
			for (int ch = 0; ch < N_CH; ch++) begin
				exp_v = c[0] ? 16'((32'(raw[ch]) * CAL_SLOPE) >> 8) + CAL_OFFSET : raw[ch];
				host.rd(DEV_DIAG_ADDR, DG_TEMP + 8'(2 * ch), d, ok);
				`CHK("diag_hi", exp_v[15:8], d)
				host.rd(DEV_DIAG_ADDR, DG_TEMP + 8'(2 * ch + 1), d, ok);
				`CHK("diag_lo", exp_v[7:0], d)
			end
			host.rd(DEV_DIAG_ADDR, DG_STATUS, d, ok);
			`CHK("status", 8'(1 << SB_INIT) | 8'(c << SB_CAL), d & 8'ha7)
		end
		host.set_dis(1'b1, 1'b1);
		cyc(4);
		`CHK("dis_off", 1'b0, laser_en_out)
		host.rd(DEV_DIAG_ADDR, DG_STATUS, d, ok);
		`CHK("status_dis", 8'(1 << SB_DIS) | 8'(1 << SB_CAL) | 8'(1 << SB_INIT), d & 8'ha7)
		host.set_dis(1'b0, 1'b0);
		cyc(4);
		`CHK("open_off", 1'b0, laser_en_out)
		host.set_dis(1'b1, 1'b0);
		cyc(4);
		`CHK("dis_on", 1'b1, laser_en_out)
		@(posedge sys_clk_in) laser_fault_in <= 1'b1;
		cyc(4);
		`CHK("fault_set", 3'b100, {tx_fault_out, tx_fault_oe_out, laser_en_out})
		@(posedge sys_clk_in) laser_fault_in <= 1'b0;
		// A pulse shorter than the reset hold leaves the fault latched
		host.set_dis(1'b1, 1'b1);
		cyc(T_RESET_CYC / 2);
		host.set_dis(1'b1, 1'b0);
		cyc(20);
		`CHK("fault_held", 1'b1, tx_fault_out)
		host.set_dis(1'b1, 1'b1);
		cyc(T_RESET_CYC + 10);
		host.set_dis(1'b1, 1'b0);
		cyc(4);
		`CHK("fault_reset", 2'b01, {tx_fault_out, laser_en_out})
		@(posedge sys_clk_in) rx_signal_detect_in <= 1'b0;
		cyc(4);
		`CHK("los_set", 2'b10, {rx_signal_absent_flag_out, rx_signal_absent_flag_oe_out})
		@(posedge sys_clk_in) rx_signal_detect_in <= 1'b1;
		cyc(4);
		`CHK("los_clr", 2'b01, {rx_signal_absent_flag_out, rx_signal_absent_flag_oe_out})
		@(posedge sys_clk_in) resetn_in <= 1'b0;
		cyc(3);
		`CHK("rst_again", 2'b10, {tx_fault_out, laser_en_out})
		@(posedge sys_clk_in) resetn_in <= 1'b1;
		cyc(INIT + 10);
		`CHK("rst_done", 2'b01, {tx_fault_out, laser_en_out})
		summarize();
	end
endmodule // optical_module_ctrl_status_tb_top
`default_nettype wire
